// ### pkg/eetws_pkg.sv
/*
  Constants for the two-wire EEPROM slave front end: slave address fields,
  glitch filter lengths and write cycle timing.
  Assumes a 200 MHz reference clock.
*/
package eetws_pkg;

  // ----------------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------------
  localparam int REF_CLK_MHZ        = 200;

  // ----------------------------------------------------------------------
  // Slave address layout
  // ----------------------------------------------------------------------
  localparam int TYPE_MSB           = 7;
  localparam int TYPE_LSB           = 4;
  localparam int BLOCK_MSB          = 3;
  localparam int BLOCK_LSB          = 1;
  localparam int RW_BIT             = 0;
  localparam logic [3:0] DEV_TYPE   = 4'h6;  // Arbitrary type code
  localparam logic RW_READ          = 1'h1;

  // ----------------------------------------------------------------------
  // Input filter, pulses shorter than this are ignored
  // ----------------------------------------------------------------------
  localparam int FILT_STD_NS        = 100;
  localparam int FILT_FAST_NS       = 50;
  localparam int FILT_STD_CYC       = (FILT_STD_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int FILT_FAST_CYC      = (FILT_FAST_NS * REF_CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------------
  // Write cycle time, longest allowed
  // ----------------------------------------------------------------------
  localparam int TWR_STD_MS         = 10;
  localparam int TWR_LOWV_MS        = 15;
  localparam int TWR_STD_CYC        = TWR_STD_MS * REF_CLK_MHZ * 1000;
  localparam int TWR_LOWV_CYC       = TWR_LOWV_MS * REF_CLK_MHZ * 1000;

endpackage

// ### hw/eetws_slave.sv
/*
  Two-wire bus slave front end of an 8 Kbit serial EEPROM.
  Assumes open-drain bus lines with external pull-ups; SCL and SDA are
  asynchronous and sampled on REF_CLK. The memory array sits outside and
  is reached through the user-side strobes.
*/
// Summary of operation
// - Internal write completes within 10 ms (15 ms low-voltage) after stop.
// - During write cycle the bus interface ignores even its own address.
// - During write cycle the data line is released high.
// - Glitches under 100 ns (standard) or 50 ns (fast) are ignored.
// - Device-select pin must match its slave address bit.
// - Receiver acknowledges each byte; withheld acknowledge ends transfer.
// - Slave receives and acks on write; master acks on read.
// - Slave address is four type bits, three block bits, one direction bit.
// - Direction bit one means read, zero means write.
// - Receiver drives data low on ninth clock, then releases it.
// - Array address byte picks one of 256 bytes in the page block.
// - Block bits without select pins choose an internal page block.
`timescale 1ns/1ps
module eetws_slave
  import eetws_pkg::*;
#(
  parameter int TWR_CYC   = TWR_STD_CYC,
  parameter int FILT_CYC  = FILT_STD_CYC
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  // Bus pins
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  input  wire logic        DEVICE_SELECT_PIN,
  // Memory side
  output logic [9:0]       MEM_ADDR,
  output logic [7:0]       MEM_WDATA,
  output logic             MEM_WR,
  output logic             MEM_RD,
  input  wire logic [7:0]  MEM_RDATA,
  output logic             WRITE_BUSY
);

  typedef enum logic [2:0] {
    EETWS_IDLE = 3'h0, EETWS_ADDR = 3'h1, EETWS_WORD = 3'h3,
    EETWS_WDATA = 3'h2, EETWS_RDATA = 3'h6, EETWS_BUSY = 3'h7
  } eetws_state_e;

  // ----------------------------------------------------------------------
  // Synchronise pins, filter SCL and SDA
  // ----------------------------------------------------------------------
  logic [1:0] scl_sync_reg, sda_sync_reg, sel_sync_reg;
  logic       scl_reg, sda_reg, scl_prev_reg, sda_prev_reg;
  logic [7:0] scl_cnt_reg, sda_cnt_reg;

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      sel_sync_reg <= 2'h0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], SCL_IN};
      sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
      sel_sync_reg <= {sel_sync_reg[0], DEVICE_SELECT_PIN};
    end
  end

  // A level is accepted only after it has held for the filter time
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      scl_reg     <= 1'h1;
      sda_reg     <= 1'h1;
      scl_cnt_reg <= 8'h00;
      sda_cnt_reg <= 8'h00;
    end else begin
      if (scl_sync_reg[1] == scl_reg) scl_cnt_reg <= 8'h00;
      else if (scl_cnt_reg >= 8'(FILT_CYC - 1)) begin
        scl_reg     <= scl_sync_reg[1];
        scl_cnt_reg <= 8'h00;
      end else scl_cnt_reg <= scl_cnt_reg + 8'h01;
      if (sda_sync_reg[1] == sda_reg) sda_cnt_reg <= 8'h00;
      else if (sda_cnt_reg >= 8'(FILT_CYC - 1)) begin
        sda_reg     <= sda_sync_reg[1];
        sda_cnt_reg <= 8'h00;
      end else sda_cnt_reg <= sda_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      scl_prev_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
    end else begin
      scl_prev_reg <= scl_reg;
      sda_prev_reg <= sda_reg;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_reg && !scl_prev_reg;
  assign scl_fall  = !scl_reg && scl_prev_reg;
  assign start_det = scl_reg && scl_prev_reg && sda_prev_reg && !sda_reg;
  assign stop_det  = scl_reg && scl_prev_reg && !sda_prev_reg && sda_reg;

  // ----------------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------------
  eetws_state_e state_reg;
  logic [3:0]   bit_cnt_reg;
  logic [7:0]   shift_reg;
  logic [1:0]   block_reg;
  logic [7:0]   word_reg;
  logic         ack_reg, sent_ack_reg, pend_wr_reg, mack_ok_reg, rd_req_reg;
  logic [31:0]  twr_cnt_reg;
  logic         addr_hit;

  // Top block bit is compared with the pin, the two lower ones pick a block
  assign addr_hit = shift_reg[TYPE_MSB:TYPE_LSB] == DEV_TYPE
                 && shift_reg[BLOCK_MSB] == sel_sync_reg[1];

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      state_reg    <= EETWS_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      block_reg    <= 2'h0;
      word_reg     <= 8'h00;
      ack_reg      <= 1'h0;
      sent_ack_reg <= 1'h0;
      pend_wr_reg  <= 1'h0;
      mack_ok_reg  <= 1'h0;
      twr_cnt_reg  <= 32'h0;
      MEM_WR       <= 1'h0;
      rd_req_reg   <= 1'h0;
      MEM_WDATA    <= 8'h00;
    end else begin
      MEM_WR <= 1'h0;
      rd_req_reg <= 1'h0;
      if (state_reg == EETWS_BUSY) begin
        // Bus events are ignored entirely here
        if (twr_cnt_reg >= 32'(TWR_CYC - 1)) begin
          state_reg <= EETWS_IDLE;
          twr_cnt_reg <= 32'h0;
        end else twr_cnt_reg <= twr_cnt_reg + 32'h1;
      end else if (start_det) begin
        state_reg   <= EETWS_ADDR;
        bit_cnt_reg <= 4'hF;  // The clock fall that closes the start is no bit
        ack_reg     <= 1'h0;
        if (pend_wr_reg) pend_wr_reg <= 1'h0;
      end else if (stop_det) begin
        ack_reg     <= 1'h0;
        state_reg   <= pend_wr_reg ? EETWS_BUSY : EETWS_IDLE;
        pend_wr_reg <= 1'h0;
        twr_cnt_reg <= 32'h0;
      end else if (state_reg != EETWS_IDLE && scl_rise) begin
        if (bit_cnt_reg < 4'h8) shift_reg <= {shift_reg[6:0], sda_reg};
        else mack_ok_reg <= !sda_reg;  // master ack on ninth clock
      end else if (state_reg != EETWS_IDLE && scl_fall) begin
        if (bit_cnt_reg == 4'h7) begin
          bit_cnt_reg <= 4'h8;
          case (state_reg)
            EETWS_ADDR: begin
              if (addr_hit) begin
                ack_reg   <= shift_reg[RW_BIT] != RW_READ;
                block_reg <= shift_reg[BLOCK_LSB+1:BLOCK_LSB];
                // Read direction acks the address too
                if (shift_reg[RW_BIT] == RW_READ) begin
                  ack_reg <= 1'h1;
                end
              end else state_reg <= EETWS_IDLE;
            end
            EETWS_WORD: begin
              word_reg <= shift_reg;
              ack_reg  <= 1'h1;
            end
            EETWS_WDATA: begin
              MEM_WDATA   <= shift_reg;
              MEM_WR      <= 1'h1;
              pend_wr_reg <= 1'h1;
              ack_reg     <= 1'h1;
            end
            default: ack_reg <= 1'h0;  // Read byte: master acks
          endcase
        end else if (bit_cnt_reg == 4'h8) begin
          ack_reg      <= 1'h0;
          bit_cnt_reg  <= 4'h0;
          sent_ack_reg <= ack_reg;
          case (state_reg)
            EETWS_ADDR: begin
              if (shift_reg[RW_BIT] == RW_READ) begin
                state_reg <= EETWS_RDATA;
                rd_req_reg <= 1'h1;
              end else state_reg <= EETWS_WORD;
            end
            EETWS_WORD:  state_reg <= EETWS_WDATA;
            EETWS_WDATA: word_reg <= word_reg + 8'h01;
            EETWS_RDATA: begin
              if (mack_ok_reg) begin
                word_reg <= word_reg + 8'h01;
                rd_req_reg <= 1'h1;
              end else state_reg <= EETWS_IDLE;
            end
            default: state_reg <= EETWS_IDLE;
          endcase
        end else bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, open drain: drive low only
  // ----------------------------------------------------------------------
  logic       rd_bit, rd_load_reg;
  logic [7:0] rd_byte_reg;
  assign rd_bit = rd_byte_reg[3'(4'h7 - bit_cnt_reg[2:0])];

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      rd_load_reg <= 1'h0;
      rd_byte_reg <= 8'h00;
    end else begin
      rd_load_reg <= MEM_RD;  // Array answers a cycle after the strobe
      if (rd_load_reg) rd_byte_reg <= MEM_RDATA;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      SDA_OE     <= 1'h0;
      SDA_OUT    <= 1'h0;
      MEM_ADDR   <= 10'h000;
      MEM_RD     <= 1'h0;
      WRITE_BUSY <= 1'h0;
    end else begin
      SDA_OUT    <= 1'h0;
      MEM_ADDR   <= {block_reg, word_reg};
      WRITE_BUSY <= state_reg == EETWS_BUSY;
      MEM_RD     <= rd_req_reg;
      if (state_reg == EETWS_BUSY || state_reg == EETWS_IDLE)
        SDA_OE <= 1'h0;
      else if (bit_cnt_reg == 4'h8)
        SDA_OE <= ack_reg;
      else if (state_reg == EETWS_RDATA && !rd_req_reg && !MEM_RD && !rd_load_reg)
        SDA_OE <= !rd_bit;
      else SDA_OE <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence busy_now_s;
    state_reg == EETWS_BUSY;
  endsequence

  busy_release_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    busy_now_s |=> !SDA_OE) else $error("data line driven during write cycle");

  busy_ignore_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (busy_now_s and start_det) |=> state_reg != EETWS_ADDR)
    else $error("address decoded during write cycle");

  busy_end_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    busy_now_s |-> twr_cnt_reg < 32'(TWR_CYC)) else $error("write cycle too long");

  busy_idle_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $fell(state_reg == EETWS_BUSY) |-> state_reg == EETWS_IDLE)
    else $error("write cycle did not return idle");

  start_abort_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    start_det && state_reg != EETWS_BUSY |=> state_reg == EETWS_ADDR && bit_cnt_reg == 4'hF)
    else $error("start did not restart decode");

  type_miss_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    state_reg == EETWS_ADDR && scl_fall && bit_cnt_reg == 4'h7 && !start_det && !stop_det
    && shift_reg[TYPE_MSB:TYPE_LSB] != DEV_TYPE |=> state_reg == EETWS_IDLE)
    else $error("foreign type accepted");

  pin_miss_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    state_reg == EETWS_ADDR && scl_fall && bit_cnt_reg == 4'h7 && !start_det && !stop_det
    && shift_reg[BLOCK_MSB] != sel_sync_reg[1] |=> state_reg == EETWS_IDLE)
    else $error("select pin mismatch accepted");

  wdata_ack_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    MEM_WR |=> ack_reg && bit_cnt_reg == 4'h8) else $error("write byte not acked");

  scl_filter_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $changed(scl_reg) |-> $past(scl_sync_reg[1]) == scl_reg)
    else $error("filtered clock changed without input");

endmodule

// ### dv/eetws_bus_master.sv
/*
  Behavioural two-wire bus master that drives the serial clock and
  pulls the data line low. Assumes the bench wires the pulled-up
  data line and feeds it back on sda_in; REF_CLK paces all timing.
*/
`timescale 1ns/1ps
module eetws_bus_master (
  // Clock
  input  wire logic clk,
  // Bus lines
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_pull
);
  initial begin
    scl_out  = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // --------------------------------------------------------------
  // Frame conditions, clock stays high between frames
  // --------------------------------------------------------------
  task automatic start_cond();
    sda_pull <= 1'b0;
    tick(10);
    scl_out  <= 1'b1;
    tick(13);
    sda_pull <= 1'b1;
    tick(13);
    scl_out  <= 1'b0;
    tick(2);
  endtask

  task automatic stop_cond();
    sda_pull <= 1'b1;
    tick(10);
    scl_out  <= 1'b1;
    tick(13);
    sda_pull <= 1'b0;
    tick(13);
  endtask

  // --------------------------------------------------------------
  // Bits and bytes, 12 cycles low and 13 high for a 125 ns period
  // --------------------------------------------------------------
  task automatic bit_xfer(input logic b, output logic r);
    sda_pull <= ~b;
    tick(10);
    scl_out  <= 1'b1;
    tick(6);
    r = sda_in;
    tick(7);
    scl_out  <= 1'b0;
    tick(2);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(~more, r);
  endtask

  // Clock spike shorter than the input filter
  task automatic glitch();
    scl_out <= 1'b1;
    tick(2);
    scl_out <= 1'b0;
    tick(4);
  endtask
endmodule

// ### dv/testbench.sv
/*
  Self-checking bench for the two-wire EEPROM slave front end.
  Assumes the bus master model and a bench memory behind the memory strobes.
*/
`timescale 1ns/1ps
module testbench
  import eetws_pkg::*;
;
  localparam int TWR = 600;
  logic       ref_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       dev_pin = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  logic       sda_out, sda_oe, mem_wr, mem_rd, write_busy, scl, m_pull, sda;
  logic [9:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem [1024];
  logic [9:0] wq_a [$];
  logic [7:0] wq_d [$];
  logic [9:0] busy_cnt = 10'h000;
  logic [9:0] busy_len = 10'h000;
  int         num_errors = 0;
  int         total_checks = 0;

  always #2.5 ref_clk = ~ref_clk;
  // Open-drain wire with pull-up
  assign sda = ~(m_pull | (sda_oe & ~sda_out));

  eetws_slave #(.TWR_CYC(TWR), .FILT_CYC(4)) dut (
    .REF_CLK(ref_clk), .NRST(nrst), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .DEVICE_SELECT_PIN(dev_pin),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_WR(mem_wr),
    .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata), .WRITE_BUSY(write_busy));

  eetws_bus_master mst (.clk(ref_clk), .sda_in(sda), .scl_out(scl), .sda_pull(m_pull));

  always @(posedge ref_clk) begin
    if (mem_rd) mem_rdata <= mem[mem_addr];
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
      wq_a.push_back(mem_addr);
      wq_d.push_back(mem_wdata);
    end
    if (write_busy) busy_cnt <= busy_cnt + 10'h001;
    else if (busy_cnt != 10'h000) begin
      busy_len <= busy_cnt;
      busy_cnt <= 10'h000;
    end
  end

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] sad(logic [3:0] t, logic p, logic [1:0] b, logic rw);
    return {t, p, b, rw};
  endfunction

  task automatic wait_idle();
    for (int i = 0; i < TWR + 100 && write_busy; i++) tick(1);
    if (write_busy !== 1'b0) begin
      num_errors++;
      wrap_up();
    end
    tick(4);
  endtask

  task automatic addr_only(input logic [7:0] sa, input logic exp);
    logic a;
    mst.start_cond();
    mst.wr_byte(sa, a);
    chk_bit(a, exp);
  endtask

  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  task automatic do_write(input logic [1:0] b, input logic [7:0] w, input int n);
    logic a;
    logic [7:0] d [$];
    wq_a.delete();
    wq_d.delete();
    addr_only(sad(DEV_TYPE, dev_pin, b, ~RW_READ), 1'b1);
    mst.wr_byte(w, a);
    chk_bit(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      d.push_back(8'($urandom));
      mst.wr_byte(d[i], a);
      chk_bit(a, 1'b1);
    end
    mst.stop_cond();
    chk_val(10'(wq_a.size()), 10'(n));
    for (int i = 0; i < n && i < wq_a.size(); i++) begin
      chk_val(wq_a[i], {b, w + 8'(i)});
      chk_val({2'h0, wq_d[i]}, {2'h0, d[i]});
    end
    tick(10);
    chk_bit(write_busy, 1'b1);
    addr_only(sad(DEV_TYPE, dev_pin, b, ~RW_READ), 1'b0);
    mst.stop_cond();
    wait_idle();
    chk_val(busy_len, 10'(TWR));
  endtask

  task automatic do_read(input logic [1:0] b, input logic [7:0] w, input int n);
    logic a;
    logic [7:0] d;
    addr_only(sad(DEV_TYPE, dev_pin, b, ~RW_READ), 1'b1);
    mst.wr_byte(w, a);
    chk_bit(a, 1'b1);
    addr_only(sad(DEV_TYPE, dev_pin, b, RW_READ), 1'b1);
    for (int i = 0; i < n; i++) begin
      mst.rd_byte(i < n - 1, d);
      chk_val({2'h0, d}, {2'h0, mem[{b, w + 8'(i)}]});
    end
    mst.stop_cond();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic       r;
    logic [1:0] b;
    logic [3:0] t;
    void'($urandom(56518));
    for (int i = 0; i < 1024; i++) mem[i] = 8'($urandom);
    tick(10);
    nrst <= 1'b1;
    tick(10);
    for (int k = 0; k < 4; k++) begin
      dev_pin <= 1'($urandom);
      b = 2'($urandom);
      tick(5);
      do_write(b, (k == 0) ? 8'hFE : 8'($urandom), 3);
      do_read(b, (k == 0) ? 8'hFE : mem_addr[7:0] - 8'h02, 3);
    end
    t = 4'($urandom);
    if (t == DEV_TYPE) t = ~t;
    addr_only(sad(t, dev_pin, b, 1'b0), 1'b0);
    mst.stop_cond();
    addr_only(sad(DEV_TYPE, ~dev_pin, b, 1'b0), 1'b0);
    mst.stop_cond();
    wq_a.delete();
    mst.start_cond();
    for (int i = 0; i < 4; i++) mst.bit_xfer(1'b0, r);
    addr_only(sad(DEV_TYPE, dev_pin, b, 1'b0), 1'b1);
    mst.wr_byte(8'h10, r);
    for (int i = 0; i < 3; i++) mst.bit_xfer(1'b1, r);
    mst.stop_cond();
    tick(20);
    chk_val(10'(wq_a.size()), 10'h000);
    chk_bit(write_busy, 1'b0);
    mst.start_cond();
    mst.glitch();
    mst.wr_byte(sad(DEV_TYPE, dev_pin, b, ~RW_READ), r);
    chk_bit(r, 1'b1);
    mst.stop_cond();
    wrap_up();
  end
endmodule
